/* design/aof_cfg.svh */
// aof_cfg.svh: constants of the converter output formatter.
// assumes inclusion by the package, the top module and the bench.
`ifndef AOF_CFG_SVH
`define AOF_CFG_SVH

// sample path
`define AOF_PIPE_DEPTH   8
`define AOF_RAW_MAX      16'sh1fff
`define AOF_RAW_MIN      16'she000
`define AOF_MSB_FLIP     14'h2000
`define AOF_WARM_MAX     4'h8

// synchronised pin positions and their reset levels
`define AOF_PIN_FMT      0
`define AOF_PIN_OEN      1
`define AOF_PIN_SUP      2
`define AOF_PIN_GND      3
`define AOF_PIN_RST      4'h2

// register offsets, byte addresses
`define AOF_ADDR_STATUS  8'h00
`define AOF_ADDR_MASK    8'h04
`define AOF_ADDR_STATE   8'h08
`define AOF_ADDR_SAMPLE  8'h0c

// status bits, responses, reset values
`define AOF_STS_OVER     0
`define AOF_STS_UNDER    1
`define AOF_STS_RST      2'h0
`define AOF_MSK_RST      2'h0
`define AOF_RESP_OKAY    2'h0
`define AOF_RESP_SLVERR  2'h2

`endif

/* design/aof_pkg.sv */
// aof_pkg: types of the converter output formatter.
// assumes aof_cfg.svh is on the include path.
`include "aof_cfg.svh"

package aof_pkg;

	// reference mode chosen from the sense comparators
	typedef enum logic [1:0] {
		AOF_REF_1V  = 2'b00,
		AOF_REF_2V  = 2'b01,
		AOF_REF_EXT = 2'b10
	} aof_ref_e;

	// whole state of the top module
	typedef struct packed {
		logic [3:0]                            s1;
		logic [3:0]                            s2;
		logic [3:0]                            s3;
		logic [3:0]                            pin;
		logic [`AOF_PIPE_DEPTH-1:0][15:0]      pipe;
		logic                                  data_oe;
		aof_ref_e                              ref_mode;
		logic                                  ref_amp_en;
		logic                                  ref_gain2;
		logic [1:0]                            sts;
		logic [1:0]                            msk;
		logic                                  irq;
		logic                                  aw_got;
		logic                                  w_got;
		logic [7:0]                            aw_addr;
		logic [31:0]                           wdata;
		logic [3:0]                            wstrb;
		logic                                  awready;
		logic                                  wready;
		logic                                  bvalid;
		logic [1:0]                            bresp;
		logic                                  arready;
		logic                                  rvalid;
		logic [31:0]                           rdata;
		logic [1:0]                            rresp;
		logic [3:0]                            warm;
	} aof_state_s;

endpackage

/* design/aof_top.sv */
// aof_top: output formatting and range flag of a 14-bit converter.
// assumes the quantiser hands a signed sample on each rising edge of
// ref_clk; strap and comparator pins are asynchronous to ref_clk.
`timescale 1ns/10ps
`include "aof_cfg.svh"

module aof_top
	import aof_pkg::*;
(
	// clock and reset
	input  wire logic               ref_clk,
	input  wire logic               reset,
	// quantiser result, lsb units around midscale
	input  wire logic signed [15:0] core_sample,
	// straps and comparator pins
	input  wire logic               format_select,
	input  wire logic               output_enable_n,
	input  wire logic               sense_at_supply,
	input  wire logic               sense_at_ground,
	// parallel sample word
	output logic [13:0]             data_word,
	output logic                    data_oe,
	output logic                    out_of_range_flag,
	// reference control
	output logic                    ref_amp_en,
	output logic                    ref_gain2,
	// interrupt
	output logic                    irq,
	// axi4-lite write
	input  wire logic [7:0]         s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]         s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready
);

	aof_state_s st_r;
	aof_state_s st_nxt;

	////////////////////////////////////////////////////////////////////
	// next-state logic

	logic signed [15:0] clamped;
	logic               over;
	logic               under;
	logic [13:0]        word;
	logic [3:0]         agree;
	logic [1:0]         clr;
	logic [1:0]         ev;
	logic               wr_ok;

	always_comb begin
		st_nxt = st_r;
		clr    = 2'h0;
		wr_ok  = 1'b0;

		// pins: three stages, a change counts once stages two and three agree
		st_nxt.s1 = {sense_at_ground, sense_at_supply, output_enable_n, format_select};
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		agree     = st_r.s2 ~^ st_r.s3;
		st_nxt.pin = (st_r.pin & ~agree) | (st_r.s3 & agree);

		// range check and clamp of the sample taken at this edge
		over    = core_sample > `AOF_RAW_MAX;
		under   = core_sample < `AOF_RAW_MIN;
		clamped = over ? `AOF_RAW_MAX : (under ? `AOF_RAW_MIN : core_sample);
		// twos complement is the clamped value, binary flips the msb
		word = st_r.pin[`AOF_PIN_FMT] ? clamped[13:0]
			: (clamped[13:0] ^ `AOF_MSB_FLIP);

		// flag rides in the same word as its data, one stage per clock
		st_nxt.pipe[0] = {over, over | under, word};
		for (int i = 1; i < `AOF_PIPE_DEPTH; i++) begin
			st_nxt.pipe[i] = st_r.pipe[i-1];
		end

		// drivers follow the filtered enable pin
		st_nxt.data_oe = ~st_r.pin[`AOF_PIN_OEN];

		// supply wins: a pin at supply also trips nothing else usefully
		if (st_r.pin[`AOF_PIN_SUP]) begin
			st_nxt.ref_mode   = AOF_REF_EXT;
			st_nxt.ref_amp_en = 1'b0;
			st_nxt.ref_gain2  = 1'b0;
		end else if (st_r.pin[`AOF_PIN_GND]) begin
			st_nxt.ref_mode   = AOF_REF_2V;
			st_nxt.ref_amp_en = 1'b1;
			st_nxt.ref_gain2  = 1'b1;
		end else begin
			st_nxt.ref_mode   = AOF_REF_1V;
			st_nxt.ref_amp_en = 1'b1;
			st_nxt.ref_gain2  = 1'b0;
		end

		// write channel capture, either order
		if (s_axi_awvalid && st_r.awready) begin
			st_nxt.aw_got  = 1'b1;
			st_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_r.wready) begin
			st_nxt.w_got = 1'b1;
			st_nxt.wdata = s_axi_wdata;
			st_nxt.wstrb = s_axi_wstrb;
		end
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end
		if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got  = 1'b0;
			st_nxt.bvalid = 1'b1;
			wr_ok = (st_r.aw_addr == `AOF_ADDR_STATUS) ||
				(st_r.aw_addr == `AOF_ADDR_MASK) ||
				(st_r.aw_addr == `AOF_ADDR_STATE) ||
				(st_r.aw_addr == `AOF_ADDR_SAMPLE);
			st_nxt.bresp = wr_ok ? `AOF_RESP_OKAY : `AOF_RESP_SLVERR;
			if (st_r.wstrb[0] && st_r.aw_addr == `AOF_ADDR_STATUS) begin
				clr = st_r.wdata[1:0];
			end
			if (st_r.wstrb[0] && st_r.aw_addr == `AOF_ADDR_MASK) begin
				st_nxt.msk = st_r.wdata[1:0];
			end
		end
		// one write at a time: no new address or data while one waits
		st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
		st_nxt.wready  = !st_nxt.w_got && !st_nxt.bvalid;

		// events come from the word entering the output stage, so the
		// status bit rises on the same edge as the flag at the pins;
		// a new event beats a clear written in the same cycle
		ev[`AOF_STS_OVER]  = st_r.pipe[`AOF_PIPE_DEPTH-2][14] &
			st_r.pipe[`AOF_PIPE_DEPTH-2][15];
		ev[`AOF_STS_UNDER] = st_r.pipe[`AOF_PIPE_DEPTH-2][14] &
			~st_r.pipe[`AOF_PIPE_DEPTH-2][15];
		st_nxt.sts = (st_r.sts & ~clr) | ev;
		st_nxt.irq = |(st_nxt.sts & st_nxt.msk);

		// read channel
		if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && st_r.arready) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp  = `AOF_RESP_OKAY;
			case (s_axi_araddr)
				`AOF_ADDR_STATUS: st_nxt.rdata = {30'h0, st_r.sts};
				`AOF_ADDR_MASK:   st_nxt.rdata = {30'h0, st_r.msk};
				`AOF_ADDR_STATE:  st_nxt.rdata = {26'h0, st_r.pipe[`AOF_PIPE_DEPTH-1][14],
					st_r.ref_mode, st_r.data_oe, st_r.pin[`AOF_PIN_OEN],
					st_r.pin[`AOF_PIN_FMT]};
				`AOF_ADDR_SAMPLE: st_nxt.rdata = {17'h0, st_r.pipe[`AOF_PIPE_DEPTH-1][14:0]};
				default: begin
					st_nxt.rdata = 32'h0;
					st_nxt.rresp = `AOF_RESP_SLVERR;
				end
			endcase
		end
		st_nxt.arready = !st_nxt.rvalid;

		// settles once the pipeline holds only post-reset samples
		if (st_r.warm != `AOF_WARM_MAX) begin
			st_nxt.warm = st_r.warm + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// state register

	// reset leaves drivers off and the pipeline at zero words
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			st_r            <= '0;
			st_r.pin        <= `AOF_PIN_RST;
			st_r.s1         <= `AOF_PIN_RST;
			st_r.s2         <= `AOF_PIN_RST;
			st_r.s3         <= `AOF_PIN_RST;
			st_r.sts        <= `AOF_STS_RST;
			st_r.msk        <= `AOF_MSK_RST;
			st_r.ref_mode   <= AOF_REF_1V;
			st_r.ref_amp_en <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs, all straight from the state register

	assign data_word         = st_r.pipe[`AOF_PIPE_DEPTH-1][13:0];
	assign out_of_range_flag = st_r.pipe[`AOF_PIPE_DEPTH-1][14];
	assign data_oe           = st_r.data_oe;
	assign ref_amp_en        = st_r.ref_amp_en;
	assign ref_gain2         = st_r.ref_gain2;
	assign irq               = st_r.irq;
	assign s_axi_awready     = st_r.awready;
	assign s_axi_wready      = st_r.wready;
	assign s_axi_bvalid      = st_r.bvalid;
	assign s_axi_bresp       = st_r.bresp;
	assign s_axi_arready     = st_r.arready;
	assign s_axi_rvalid      = st_r.rvalid;
	assign s_axi_rdata       = st_r.rdata;
	assign s_axi_rresp       = st_r.rresp;

	////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	logic warm;
	logic in_rng;
	assign warm   = st_r.warm == `AOF_WARM_MAX;
	assign in_rng = core_sample <= `AOF_RAW_MAX && core_sample >= `AOF_RAW_MIN;

	// an in-range sample, then its flag low eight clocks later
	sequence in_range_taken;
		in_rng && st_r.warm >= 4'h1;
	endsequence
	sequence flag_low_out;
		##8 !out_of_range_flag;
	endsequence

	fmt_binary_a: assert property (warm && !$past(st_r.pin[0], 8) && $past(in_rng, 8)
		|-> data_word == ($past(core_sample[13:0], 8) ^ 14'h2000))
		else $error("binary word wrong");
	fmt_twos_a: assert property (warm && $past(st_r.pin[0], 8) && $past(in_rng, 8)
		|-> data_word == $past(core_sample[13:0], 8))
		else $error("twos complement word wrong");
	top_code_a: assert property (warm && $past(core_sample, 8) == 16'sh1fff
		|-> !out_of_range_flag && data_word == ($past(st_r.pin[0], 8) ? 14'h1fff : 14'h3fff))
		else $error("top code wrong");
	clamp_high_a: assert property (warm && $past(core_sample, 8) > 16'sh1fff
		|-> out_of_range_flag && data_word == ($past(st_r.pin[0], 8) ? 14'h1fff : 14'h3fff))
		else $error("overrange clamp wrong");
	clamp_low_a: assert property (warm && $past(core_sample, 8) <= 16'she000
		|-> data_word == ($past(st_r.pin[0], 8) ? 14'h2000 : 14'h0000)
		&& out_of_range_flag == ($past(core_sample, 8) != 16'she000))
		else $error("underrange clamp wrong");
	zero_code_a: assert property (warm && $past(core_sample, 8) == 16'sh0000
		|-> data_word == ($past(st_r.pin[0], 8) ? 14'h0000 : 14'h2000))
		else $error("midscale code wrong");
	flag_latency_a: assert property (warm
		|-> out_of_range_flag == !$past(in_rng, 8))
		else $error("flag latency wrong");
	flag_release_a: assert property (in_range_taken |-> flag_low_out)
		else $error("flag not released");
	ref_decode_a: assert property ($past(st_r.pin[2]) |-> !ref_amp_en && !ref_gain2)
		else $error("external reference decode wrong");
	ref_gain_a: assert property (!$past(st_r.pin[2])
		|-> ref_amp_en && ref_gain2 == $past(st_r.pin[3]))
		else $error("internal reference decode wrong");
	oe_follow_a: assert property ($changed(st_r.pin[1]) |=> data_oe == !$past(st_r.pin[1]))
		else $error("drive enable wrong");
	irq_sticky_a: assert property (st_r.sts != 2'h0 && st_r.msk == st_r.sts |-> irq)
		else $error("interrupt not raised");

endmodule

/* testbench/aof_capture.sv */
// aof_capture: downstream capture logic that sorts each word into a range class.
// assumes it sees the parallel word and flag as the converter drives them.
`timescale 1ns/10ps

module aof_capture (
	// sample word from the converter
	input  wire logic [13:0] data_word,
	input  wire logic        out_of_range_flag,
	input  wire logic        twos_mode,
	// range class of the word on the pins
	output logic             over,
	output logic             under
);
	// offset-binary msb; the twos sign bit is its inverse
	logic msb;
	assign msb = data_word[13] ^ twos_mode;

	// flag alone says out of range, msb picks the side
	always_comb begin
		over  = out_of_range_flag & msb;
		under = out_of_range_flag & ~msb;
	end
endmodule

/* testbench/adc_output_format_and_range_flag_bench.sv */
// adc_output_format_and_range_flag_bench: self-checking bench of aof_top.
// assumes axi answers and pin filters settle well inside 50 and 16 clocks.
`timescale 1ns/10ps
`include "aof_cfg.svh"

module adc_output_format_and_range_flag_bench;
	import aof_pkg::*;

	// design pins, the inputs all given a value at time zero
	logic               ref_clk = 1'b0, reset = 1'b1;
	logic signed [15:0] core_sample = '0;
	logic               format_select = 1'b0, output_enable_n = 1'b0;
	logic               sense_at_supply = 1'b0, sense_at_ground = 1'b0;
	logic [13:0]        data_word;
	logic               data_oe, out_of_range_flag, ref_amp_en, ref_gain2, irq, over, under;
	logic [7:0]         awaddr = '0, araddr = '0;
	logic [31:0]        wdata = '0, rdata;
	logic [3:0]         wstrb = '0;
	logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic               arvalid = 1'b0, rready = 1'b0;
	logic               awready, wready, bvalid, arready, rvalid;
	logic [1:0]         bresp, rresp;
	int                 fail_count = 0, tests_run = 0;
	logic               chk_en = 1'b0;
	logic signed [15:0] hist [$];
	logic signed [15:0] edge_v [10] = '{16'sd8191, 16'sd8190, 16'sd8192, 16'sd0,
		-16'sd8192, -16'sd8193, 16'sd32767, -16'sd32768, 16'sd1, -16'sd1};

	always #10 ref_clk = ~ref_clk;

	aof_top dut (.ref_clk(ref_clk), .reset(reset), .core_sample(core_sample),
		.format_select(format_select), .output_enable_n(output_enable_n),
		.sense_at_supply(sense_at_supply), .sense_at_ground(sense_at_ground),
		.data_word(data_word), .data_oe(data_oe), .out_of_range_flag(out_of_range_flag),
		.ref_amp_en(ref_amp_en), .ref_gain2(ref_gain2), .irq(irq),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));

	aof_capture cap (.data_word(data_word), .out_of_range_flag(out_of_range_flag),
		.twos_mode(format_select), .over(over), .under(under));

	////////////////////////////////////////////////////////////////////////////
	// comparison, verdict and bounded-wait helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			fail_count++;
		end
	endtask

	task automatic end_sim;
		$display("compares %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// a used-up wait counts as a mismatch and ends the run
	task automatic give_up(input int n);
		if (n >= 50) begin
			chk(32'h0, 32'h1);
			end_sim;
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	// axi4-lite master, one transfer at a time
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		logic aw, w;
		n = 0;
		aw = 1'b0;
		w = 1'b0;
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw && w) && n < 50) begin
			@(posedge ref_clk);
			if (!aw && awready === 1'b1) begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w && wready === 1'b1) begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
			n++;
		end
		give_up(n);
		n = 0;
		do begin @(posedge ref_clk); n++; end while (bvalid !== 1'b1 && n < 50);
		give_up(n);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin @(posedge ref_clk); n++; end while (arready !== 1'b1 && n < 50);
		give_up(n);
		arvalid <= 1'b0;
		n = 0;
		while (rvalid !== 1'b1 && n < 50) begin @(posedge ref_clk); n++; end
		give_up(n);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// one sample for one clock, then midscale until it has come out
	task automatic pulse(input logic signed [15:0] v);
		@(posedge ref_clk);
		core_sample <= v;
		@(posedge ref_clk);
		core_sample <= 16'sd0;
		repeat (12) @(posedge ref_clk);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// reference model: history as deep as the pipeline, checked mid-cycle
	always @(posedge ref_clk) begin
		hist.push_back(core_sample);
		if (hist.size() > 8) void'(hist.pop_front());
	end

	always @(negedge ref_clk) begin
		logic signed [15:0] s;
		int c;
		logic [13:0] e;
		if (chk_en && hist.size() == 8) begin
			s = hist[0];
			c = s > 8191 ? 8191 : (s < -8192 ? -8192 : int'(s));
			// binary flips the top bit of the clamped value, twos keeps it
			e = 14'(c) ^ (format_select ? 14'h0 : 14'h2000);
			chk(32'(data_word), 32'(e));
			chk(32'(out_of_range_flag), 32'(s > 8191 || s < -8192));
			chk(32'({over, under}), 32'({s > 8191, s < -8192}));
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [1:0] e;
		void'($urandom(66609));
		repeat (10) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (4) @(posedge ref_clk);
		// reset values, unmapped place, interrupt raise, clear and mask
		axi_rd(`AOF_ADDR_STATUS, d, r);
		chk(d, 32'h0);
		axi_rd(`AOF_ADDR_MASK, d, r);
		chk(d, 32'h0);
		axi_rd(8'h40, d, r);
		chk(32'(r), 32'(`AOF_RESP_SLVERR));
		axi_wr(8'h40, 32'h3, r);
		chk(32'(r), 32'(`AOF_RESP_SLVERR));
		axi_wr(`AOF_ADDR_MASK, 32'h1, r);
		chk(32'(r), 32'(`AOF_RESP_OKAY));
		pulse(16'sd9000);
		chk(32'(irq), 32'h1);
		axi_rd(`AOF_ADDR_STATUS, d, r);
		chk(d, 32'h1);
		// midscale input in binary mode sits at the pins by now
		axi_rd(`AOF_ADDR_SAMPLE, d, r);
		chk(d, 32'h2000);
		axi_wr(`AOF_ADDR_STATUS, 32'h1, r);
		axi_rd(`AOF_ADDR_STATUS, d, r);
		chk(d, 32'h0);
		chk(32'(irq), 32'h0);
		pulse(-16'sd9000);
		chk(32'(irq), 32'h0);
		axi_rd(`AOF_ADDR_STATUS, d, r);
		chk(d, 32'h2);
		// output enable and every sense combination
		for (int i = 0; i < 8; i++) begin
			{output_enable_n, sense_at_supply, sense_at_ground} <= 3'(i);
			repeat (8) @(posedge ref_clk);
			chk(32'(data_oe), 32'(!output_enable_n));
			e = {!sense_at_supply, !sense_at_supply && sense_at_ground};
			chk(32'({ref_amp_en, ref_gain2}), 32'(e));
		end
		output_enable_n <= 1'b0;
		// mid-run reset: drivers off, 1 V reference, status and mask cleared
		reset <= 1'b1;
		repeat (3) @(posedge ref_clk);
		chk(32'({data_oe, ref_amp_en, ref_gain2, irq, out_of_range_flag}), 32'h8);
		reset <= 1'b0;
		repeat (4) @(posedge ref_clk);
		axi_rd(`AOF_ADDR_MASK, d, r);
		chk(d, 32'h0);
		axi_rd(`AOF_ADDR_STATUS, d, r);
		chk(d, 32'h0);
		// boundary and random streams in both formats
		for (int f = 0; f < 2; f++) begin
			chk_en <= 1'b0;
			format_select <= f[0];
			// settling gap, scaled far down, before results are trusted
			repeat (16) @(posedge ref_clk);
			chk_en <= 1'b1;
			foreach (edge_v[k]) begin
				core_sample <= edge_v[k];
				@(posedge ref_clk);
			end
			repeat (300) begin
				core_sample <= 16'($urandom_range(18000)) - 16'sd9000;
				@(posedge ref_clk);
			end
		end
		chk_en <= 1'b0;
		end_sim;
	end
endmodule
